// ===== logic/srt_top.sv
/*
 * Two-channel synchronous rectifier controller with light-load sleep logic,
 * below-resonance cut-off, startup strap capture and an APB register file.
 * Assumes comparator, strap and half-period clock inputs synchronous to pclk.
 */
`timescale 1ns/1ps
`include "srt_params.svh"
module srt_top (
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // supply and startup straps
   input  wire logic              supply_ok,
   input  wire srt_pkg::srt_code_t en_strap_code,
   input  wire srt_pkg::srt_code_t level_program_pin,
   // sensed waveforms
   input  wire logic              half_period_clk,
   input  wire logic [1:0]        conduction_onset_threshold,
   input  wire logic [1:0]        zero_current_turnoff_comparator,
   input  wire logic [1:0]        adaptive_off_req,
   // gate drivers
   output logic [1:0]             gate_drv,
   output logic [1:0]             hard_pulldown,
   output logic [3:0]             zcd_trim0,
   output logic [3:0]             zcd_trim1,
   output logic                   sleep_active
);
   import srt_pkg::*;

   srt_top_st_t q;
   srt_top_st_t n;
   logic        drv_en;
   logic [15:0] on_limit;
   logic        sleeping;

   srt_ch_if ch_if [2] ();

   // ----------------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------------
   assign drv_en = q.ctrl_en & q.cfg_done & ~q.below_res &
                   (q.state == ST_RUN || q.state == ST_SOFT);
   assign on_limit = (q.state == ST_SOFT) ? q.limit : 16'hFFFF;
   assign sleeping = (q.state == ST_HOLD || q.state == ST_SLEEP);

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ch
         assign ch_if[gi].cond_in = conduction_onset_threshold[gi];
         assign ch_if[gi].zcd_in = zero_current_turnoff_comparator[gi];
         assign ch_if[gi].adapt_off = adaptive_off_req[gi];
         assign ch_if[gi].drive_en = drv_en;
         assign ch_if[gi].sleeping = sleeping;
         assign ch_if[gi].on_limit = on_limit;
         assign gate_drv[gi] = ch_if[gi].gate;
         assign hard_pulldown[gi] = ch_if[gi].fast_off;
         srt_chan u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .ch      (ch_if[gi].chan)
         );
      end
   endgenerate

   assign zcd_trim0 = ch_if[0].trim;
   assign zcd_trim1 = ch_if[1].trim;
   assign sleep_active = q.cfg_done & (q.state != ST_RUN);
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic        tick;
      logic        fall;
      logic [15:0] cur_hp;
      logic [31:0] cond_x100;
      logic [31:0] off_lvl;
      logic [31:0] on_lvl;
      logic        duty_low;
      logic        duty_high;
      logic        wr;
      logic        rd;
      tick = half_period_clk & ~q.hp_prev;
      fall = ~half_period_clk & q.hp_prev;
      cur_hp = q.hp;
      cond_x100 = 32'h0000_0000;
      off_lvl = 32'h0000_0000;
      on_lvl = 32'h0000_0000;
      duty_low = 1'b0;
      duty_high = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      n = q;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      n.hp_prev = half_period_clk;

      if (fall) begin
         n.hp_cnt = 16'h0001;
      end else if (!half_period_clk && q.hp_cnt != 16'hFFFF) begin
         n.hp_cnt = q.hp_cnt + 16'h0001;
      end
      if (tick) begin
         cur_hp = q.hp_cnt;
         n.hp = q.hp_cnt;
         n.below_res = (q.res_hp != 16'h0000) &&
                       ({16'h0000, q.hp_cnt} * `SRT_RES_STOP_PCT >
                        {16'h0000, q.res_hp} * 32'd100);
      end

      // latest conduction result of either channel
      if (ch_if[0].done) begin
         n.last_cond = ch_if[0].cond_time;
      end else if (ch_if[1].done) begin
         n.last_cond = ch_if[1].cond_time;
      end

      cond_x100 = {16'h0000, q.last_cond} * 32'd100;
      off_lvl = {16'h0000, cur_hp} * {25'h0000000, q.doff};
      on_lvl = {16'h0000, cur_hp} * {25'h0000000, q.don};
      duty_low = cond_x100 < off_lvl;
      duty_high = cond_x100 > on_lvl;

      // ----------------------------------------------------------------------
      // sleep sequencing, one step per half-period
      // ----------------------------------------------------------------------
      if (tick) begin
         case (q.state)
            ST_RUN: begin
               if (q.sleep_en && duty_low) begin
                  if (q.cnt == `SRT_ENTRY_CYCLES - 10'd1) begin
                     n.state = ST_SOFT;
                     n.cnt = 10'h000;
                     n.limit = q.last_cond;
                     n.hold = 4'h0;
                  end else begin
                     n.cnt = q.cnt + 10'h001;
                  end
               end else begin
                  n.cnt = 10'h000;
               end
            end
            ST_SOFT: begin
               if (!duty_low) begin
                  n.state = ST_RUN;
               end else if (q.hold == `SRT_SOFT_STEPS - 4'h1) begin
                  n.state = ST_HOLD;
                  n.hold = 4'h0;
               end else begin
                  n.hold = q.hold + 4'h1;
                  n.limit = q.limit - (q.limit >> 2) - {15'h0000, (q.limit != 16'h0000)};
               end
            end
            ST_HOLD: begin
               if (q.hold == `SRT_HOLD_CYCLES - 4'h1) begin
                  n.state = ST_SLEEP;
                  n.acc = 32'h0000_0000;
               end else begin
                  n.hold = q.hold + 4'h1;
               end
            end
            ST_SLEEP: begin
               if (duty_high) begin
                  if (q.acc + (cond_x100 - on_lvl) >= {16'h0000, cur_hp} * `SRT_EXIT_SCALE) begin
                     n.state = ST_RUN;
                     n.cnt = 10'h000;
                     n.acc = 32'h0000_0000;
                  end else begin
                     n.acc = q.acc + (cond_x100 - on_lvl);
                  end
               end else begin
                  n.acc = 32'h0000_0000;
               end
            end
            default: begin
               n.state = ST_RUN;
            end
         endcase
      end

      // ----------------------------------------------------------------------
      // startup straps
      // ----------------------------------------------------------------------
      n.supply_prev = supply_ok;
      if (!supply_ok) begin
         n.cfg_done = 1'b0;
         n.state = ST_RUN;
         n.cnt = 10'h000;
      end else if (!q.supply_prev && !q.cfg_done) begin
         n.cfg_done = 1'b1;
         n.sleep_en = (en_strap_code == 2'b00) || (en_strap_code == 2'b01);
         case (en_strap_code)
            2'b00: begin
               n.doff = `SRT_DOFF_T1;
               case (level_program_pin)
                  2'b00:   n.don = `SRT_DON_T1_0;
                  2'b01:   n.don = `SRT_DON_T1_1;
                  2'b10:   n.don = `SRT_DON_T1_2;
                  default: n.don = `SRT_DON_T1_3;
               endcase
            end
            2'b01: begin
               n.doff = `SRT_DOFF_T2;
               case (level_program_pin)
                  2'b00:   n.don = `SRT_DON_T2_0;
                  2'b01:   n.don = `SRT_DON_T2_1;
                  2'b10:   n.don = `SRT_DON_T2_2;
                  default: n.don = `SRT_DON_T2_3;
               endcase
            end
            default: begin
               n.doff = 7'h00;
               case (level_program_pin)
                  2'b00:   n.don = `SRT_DON_T3_0;
                  2'b01:   n.don = `SRT_DON_T3_1;
                  2'b10:   n.don = `SRT_DON_T3_2;
                  default: n.don = `SRT_DON_T3_3;
               endcase
            end
         endcase
      end

      // ----------------------------------------------------------------------
      // apb access, answered one cycle into the access phase
      // ----------------------------------------------------------------------
      if (psel && penable && !q.pready) begin
         n.pready = 1'b1;
         n.prdata = 32'h0000_0000;
         case (paddr)
            `SRT_OFF_CTRL:     n.prdata = {31'h00000000, q.ctrl_en};
            `SRT_OFF_RES_HP:   n.prdata = {16'h0000, q.res_hp};
            `SRT_OFF_STATUS:   n.prdata = {24'h000000, q.below_res, q.sleep_en, q.cfg_done,
                                           1'b0, gate_drv, q.state};
            `SRT_OFF_HALF_PER: n.prdata = {16'h0000, q.hp};
            `SRT_OFF_COND:     n.prdata = {ch_if[1].cond_time, ch_if[0].cond_time};
            `SRT_OFF_CONFIG:   n.prdata = {16'h0000, 1'b0, q.don, 1'b0, q.doff};
            default:           n.pslverr = 1'b1;
         endcase
      end
      wr = psel && penable && q.pready && pwrite;
      rd = psel && penable && q.pready && !pwrite;
      if (rd) begin
         n.prdata = q.prdata;
      end
      if (wr) begin
         case (paddr)
            `SRT_OFF_CTRL:   n.ctrl_en = pwdata[0];
            `SRT_OFF_RES_HP: n.res_hp = pwdata[15:0];
            default:         n.ctrl_en = q.ctrl_en;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.state <= ST_RUN;
         // idle level of the half-period clock, no false tick after reset
         q.hp_prev <= 1'b1;
         q.ctrl_en <= `SRT_CTRL_RST;
         q.res_hp <= `SRT_RES_HP_RST;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   chk_below_res_stop: assert property (@(posedge pclk) disable iff (!presetn)
      q.below_res |=> (!$rose(gate_drv[0]) && !$rose(gate_drv[1])))
      else $error("gate turned on below resonance");
   chk_entry_count: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == ST_RUN && n.state == ST_SOFT) |-> (q.cnt == 10'd511 && q.sleep_en))
      else $error("sleep entry without 512 confirmations");
   chk_sleep_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      !q.sleep_en |-> q.state == ST_RUN)
      else $error("sleep sequence while sleep disabled");
   chk_hold_len: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == ST_HOLD && n.state == ST_SLEEP) |-> q.hold == 4'd7)
      else $error("sleep hold not 8 cycles");
   chk_soft_shrink: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == ST_SOFT && n.state == ST_SOFT && n.hold != q.hold) |=>
      (q.limit < $past(q.limit) || q.limit == 16'h0000))
      else $error("soft transition did not shorten conduction");
   chk_cfg_held: assert property (@(posedge pclk) disable iff (!presetn)
      (q.cfg_done && $past(q.cfg_done)) |-> ($stable(q.don) && $stable(q.doff) &&
      $stable(q.sleep_en)))
      else $error("startup configuration changed while supplied");
   chk_sleep_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
      (q.state == ST_HOLD) |=> !$rose(gate_drv[0]))
      else $error("gate turned on while sleeping");
   chk_half_latch: assert property (@(posedge pclk) disable iff (!presetn)
      (half_period_clk && !q.hp_prev) |=> q.hp == $past(q.hp_cnt))
      else $error("half-period not latched at rising edge");
   chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !q.pready) |=> q.pready)
      else $error("apb access not answered");
endmodule

// ===== logic/srt_params.svh
/*
 * Constants of the rectifier controller: register offsets, reset values,
 * timing counts and the startup duty lookup tables.
 * Assumes a 10 MHz pclk; all counts are in pclk cycles or sensed half-periods.
 */
`ifndef SRT_PARAMS_SVH
`define SRT_PARAMS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SRT_CLK_PERIOD_NS 100
`define SRT_BLANK_NS      450
`define SRT_BLANK_CYC     ((`SRT_BLANK_NS + `SRT_CLK_PERIOD_NS - 1) / `SRT_CLK_PERIOD_NS)
`define SRT_ENTRY_CYCLES  10'd512
`define SRT_HOLD_CYCLES   4'd8
`define SRT_SOFT_STEPS    4'd4
`define SRT_RES_STOP_PCT  32'd60
`define SRT_EXIT_SCALE    32'd32

// ----------------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------------
`define SRT_OFF_CTRL      8'h00
`define SRT_OFF_RES_HP    8'h04
`define SRT_OFF_STATUS    8'h08
`define SRT_OFF_HALF_PER  8'h0C
`define SRT_OFF_COND      8'h10
`define SRT_OFF_CONFIG    8'h14
`define SRT_CTRL_RST      1'b1
`define SRT_RES_HP_RST    16'h0000
`define SRT_TRIM_RST      4'h8

// ----------------------------------------------------------------------
// duty levels in percent
// ----------------------------------------------------------------------
`define SRT_DOFF_T1       7'd40
`define SRT_DOFF_T2       7'd25
`define SRT_DON_T1_0      7'd80
`define SRT_DON_T1_1      7'd75
`define SRT_DON_T1_2      7'd65
`define SRT_DON_T1_3      7'd60
`define SRT_DON_T2_0      7'd75
`define SRT_DON_T2_1      7'd70
`define SRT_DON_T2_2      7'd60
`define SRT_DON_T2_3      7'd55
`define SRT_DON_T3_0      7'd80
`define SRT_DON_T3_1      7'd75
`define SRT_DON_T3_2      7'd65
`define SRT_DON_T3_3      7'd0

`endif

// ===== logic/srt_pkg.sv
/*
 * Types of the rectifier controller: sleep states and state records.
 * Assumes srt_params.svh for all numeric constants.
 */
package srt_pkg;

   typedef logic [1:0] srt_code_t;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_SOFT  = 2'b01,
      ST_HOLD  = 2'b10,
      ST_SLEEP = 2'b11
   } srt_state_t;

   typedef struct packed {
      logic        gate;
      logic        fast;
      logic [2:0]  blank;
      logic [15:0] on_cnt;
      logic        meas;
      logic [15:0] meas_cnt;
      logic        cond_prev;
      logic [3:0]  trim;
      logic        done;
      logic [15:0] cond_time;
   } srt_chan_st_t;

   typedef struct packed {
      logic        cfg_done;
      logic        supply_prev;
      logic        sleep_en;
      logic [6:0]  doff;
      logic [6:0]  don;
      srt_state_t  state;
      logic [9:0]  cnt;
      logic [3:0]  hold;
      logic [15:0] limit;
      logic [31:0] acc;
      logic        hp_prev;
      logic [15:0] hp_cnt;
      logic [15:0] hp;
      logic [15:0] last_cond;
      logic        below_res;
      logic        ctrl_en;
      logic [15:0] res_hp;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } srt_top_st_t;

endpackage

// ===== logic/srt_ch_if.sv
/*
 * Link between the sleep controller and one rectifier channel.
 * Assumes one instance per channel, all signals in the pclk domain.
 */
`timescale 1ns/1ps
interface srt_ch_if;
   logic        cond_in;
   logic        zcd_in;
   logic        adapt_off;
   logic        drive_en;
   logic        sleeping;
   logic [15:0] on_limit;
   logic        gate;
   logic        fast_off;
   logic [3:0]  trim;
   logic        done;
   logic [15:0] cond_time;

   modport chan (input cond_in, zcd_in, adapt_off, drive_en, sleeping, on_limit,
                 output gate, fast_off, trim, done, cond_time);
   modport ctrl (output cond_in, zcd_in, adapt_off, drive_en, sleeping, on_limit,
                 input gate, fast_off, trim, done, cond_time);
endinterface

// ===== logic/srt_chan.sv
/*
 * One rectifier channel: gate turn-on, blanking, fast and slow turn-off,
 * zero-current trip trim and conduction time measurement.
 * Assumes comparator inputs already synchronous to pclk.
 */
`timescale 1ns/1ps
`include "srt_params.svh"
module srt_chan (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // link to controller
   srt_ch_if.chan    ch
);
   import srt_pkg::*;

   srt_chan_st_t q;
   srt_chan_st_t n;

   always_comb begin
      logic rise;
      logic fall;
      rise = ch.cond_in & ~q.cond_prev;
      fall = ~ch.cond_in & q.cond_prev;
      n = q;
      n.done = 1'b0;
      n.cond_prev = ch.cond_in;
      if (!q.gate) begin
         if (rise && ch.drive_en) begin
            n.gate = 1'b1;
            n.fast = 1'b0;
            n.blank = 3'(`SRT_BLANK_CYC);
            n.on_cnt = 16'h0000;
         end
      end else begin
         if (q.on_cnt != 16'hFFFF) n.on_cnt = q.on_cnt + 16'h0001;
         if (q.blank != 3'h0) n.blank = q.blank - 3'h1;
         if (q.blank == 3'h0 && ch.zcd_in) begin
            n.gate = 1'b0;
            n.fast = 1'b1;
            if (q.trim != 4'hF) n.trim = q.trim + 4'h1;
         end else if (ch.adapt_off || q.on_cnt >= ch.on_limit || !ch.drive_en) begin
            n.gate = 1'b0;
            n.fast = 1'b0;
            if (ch.adapt_off && q.trim != 4'h0) n.trim = q.trim - 4'h1;
         end
      end
      if (rise) begin
         n.meas = 1'b1;
         n.meas_cnt = 16'h0000;
      end else if (q.meas) begin
         if (q.meas_cnt != 16'hFFFF) n.meas_cnt = q.meas_cnt + 16'h0001;
         if ((q.gate && !n.gate && !ch.sleeping) || (fall && (ch.sleeping || !q.gate))) begin
            n.meas = 1'b0;
            n.done = 1'b1;
            n.cond_time = q.meas_cnt;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.trim <= `SRT_TRIM_RST;
      end else begin
         q <= n;
      end
   end

   assign ch.gate = q.gate;
   assign ch.fast_off = q.fast;
   assign ch.trim = q.trim;
   assign ch.done = q.done;
   assign ch.cond_time = q.cond_time;

   chk_blank_window: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(q.gate) |-> ##1 (!q.fast) [*5])
      else $error("fast turn-off inside blanking window");
   chk_zcd_fast_off: assert property (@(posedge pclk) disable iff (!presetn)
      (q.gate && q.blank == 3'h0 && ch.zcd_in) |=> (!q.gate && q.fast))
      else $error("zero-current trip did not force fast turn-off");
   chk_adapt_slow_off: assert property (@(posedge pclk) disable iff (!presetn)
      (q.gate && !(q.blank == 3'h0 && ch.zcd_in) && ch.adapt_off) |=> (!q.gate && !q.fast))
      else $error("adaptive turn-off not on slow path");
endmodule

// ===== testbench/srt_rect_model.sv
/*
 * Sensed waveform source for srt_top: half-period clock and onset.
 * Assumes pclk at 10 MHz and a bench that sets the low span and conduction.
 */
`timescale 1ns/1ps
module srt_rect_model (
   // clock and control
   input  wire logic        pclk,
   input  wire logic        run,
   input  wire logic        cond_en,
   input  wire logic [15:0] lo_cyc,
   // sensed waveforms
   output logic             half_period_clk,
   output logic [1:0]       onset
);
   logic [15:0] cnt_q;

   // low for lo_cyc cycles, high for two
   always_ff @(posedge pclk) begin
      if (!run || cnt_q == lo_cyc + 16'h1) begin
         cnt_q <= 16'h0;
      end else begin
         cnt_q <= cnt_q + 16'h1;
      end
   end

   // clock idles high; diode conducts through the low span only
   assign half_period_clk = !run || cnt_q >= lo_cyc;
   assign onset           = {1'b0, run && cond_en && cnt_q < lo_cyc};
endmodule

// ===== testbench/srt_top_tb.sv
/*
 * Bench for srt_top: APB registers, straps, turn-off paths, sleep.
 * Assumes srt_rect_model as the sensed waveform source.
 */
`timescale 1ns/1ps
`include "srt_params.svh"
module srt_top_tb;
   import srt_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        supply_ok = 0, run = 0, cond_en = 0, er, pready, pslverr;
   logic        hpc, sleep_active;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] lo = 16'hA;
   srt_code_t   en_code = 0, pin = 0;
   logic [1:0]  onset_m, onset_b = 0, zcd = 0, adp = 0, gate_drv, hard_pulldown;
   logic [3:0]  trim0, trim1;
   int          errors = 0, n_checks = 0;

   always #50 pclk = ~pclk;

   srt_rect_model u_mdl (.pclk(pclk), .run(run), .cond_en(cond_en), .lo_cyc(lo),
      .half_period_clk(hpc), .onset(onset_m));

   srt_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
      .en_strap_code(en_code), .level_program_pin(pin), .half_period_clk(hpc),
      .conduction_onset_threshold(onset_m | onset_b),
      .zero_current_turnoff_comparator(zcd), .adaptive_off_req(adp),
      .gate_drv(gate_drv), .hard_pulldown(hard_pulldown), .zcd_trim0(trim0),
      .zcd_trim1(trim1), .sleep_active(sleep_active));

   task results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task chk(input logic ok, input string m);
      n_checks++;
      if (!ok) begin
         errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      chk(n < 40, "no pready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task ticks(input int n);
      repeat (n) @(posedge hpc);
      @(negedge pclk);
   endtask

   task t_regs;
      apb(0, `SRT_OFF_CTRL, 0);
      chk(rd[0] === `SRT_CTRL_RST && er === 1'b0, "ctrl reset");
      apb(0, `SRT_OFF_RES_HP, 0);
      chk(rd[15:0] === `SRT_RES_HP_RST, "res_hp reset");
      apb(1, 8'h18, 32'hFFFF);
      chk(er === 1'b1, "unmapped write");
      apb(0, 8'h18, 0);
      chk(er === 1'b1 && rd === 32'h0, "unmapped read");
      apb(1, `SRT_OFF_RES_HP, 32'h1234);
      apb(0, `SRT_OFF_RES_HP, 0);
      chk(rd[15:0] === 16'h1234, "res_hp rw");
      apb(1, `SRT_OFF_RES_HP, 0);
      chk(trim0 === `SRT_TRIM_RST && gate_drv === 2'h0, "reset outputs");
   endtask

   task t_strap(input srt_code_t e, input srt_code_t p, input logic [15:0] x,
                input logic [15:0] m);
      @(posedge pclk);
      supply_ok <= 1'b0;
      en_code <= e;
      pin <= p;
      @(posedge pclk);
      supply_ok <= 1'b1;
      @(posedge pclk);
      pin <= ~p;
      apb(0, `SRT_OFF_CONFIG, 0);
      chk((rd[15:0] & m) === x, "duty levels");
      apb(0, `SRT_OFF_STATUS, 0);
      chk(rd[6:5] === {e < 2'h2, 1'b1}, "sleep enable");
   endtask

   task t_nosleep;
      run <= 1'b1;
      ticks(600);
      chk(sleep_active === 1'b0, "sleep while disabled");
      run <= 1'b0;
   endtask

   task t_zcd;
      int n;
      n = 0;
      @(posedge pclk);
      onset_b <= 2'h1;
      zcd <= 2'h1;
      repeat (12) begin
         @(negedge pclk);
         if (gate_drv[0] === 1'b1) n++;
         chk(gate_drv[1] === 1'b0, "other channel moved");
      end
      chk(n >= 5 && n <= 7, "blanking span");
      chk(hard_pulldown === 2'h1 && trim0 === 4'h9, "hard off, trim");
      @(posedge pclk);
      onset_b <= 2'h0;
      zcd <= 2'h0;
   endtask

   task t_adp;
      @(posedge pclk);
      onset_b <= 2'h1;
      repeat (3) @(negedge pclk);
      chk(gate_drv[0] === 1'b1, "gate on");
      @(posedge pclk);
      adp <= 2'h1;
      repeat (3) @(negedge pclk);
      chk(gate_drv[0] === 1'b0 && hard_pulldown[0] === 1'b0, "slow off");
      chk(trim0 === `SRT_TRIM_RST, "trim down");
      @(posedge pclk);
      adp <= 2'h0;
      onset_b <= 2'h0;
   endtask

   task t_below;
      apb(1, `SRT_OFF_RES_HP, 32'hA);
      lo <= 16'h14;
      run <= 1'b1;
      ticks(3);
      apb(0, `SRT_OFF_HALF_PER, 0);
      chk(rd[15:0] === 16'h14, "half period");
      apb(0, `SRT_OFF_STATUS, 0);
      chk(rd[7] === 1'b1, "below resonance");
      @(posedge pclk);
      onset_b <= 2'h3;
      repeat (4) @(negedge pclk);
      chk(gate_drv === 2'h0, "drive below resonance");
      @(posedge pclk);
      onset_b <= 2'h0;
      apb(1, `SRT_OFF_RES_HP, 0);
      ticks(2);
      apb(0, `SRT_OFF_STATUS, 0);
      chk(rd[7] === 1'b0, "resonance cleared");
      run <= 1'b0;
   endtask

   task t_sleep;
      int n;
      n = 0;
      t_strap(2'h0, 2'h0, {1'b0, `SRT_DON_T1_0, 1'b0, `SRT_DOFF_T1}, 16'h7F7F);
      lo <= 16'hA;
      run <= 1'b1;
      ticks(500);
      chk(sleep_active === 1'b0, "early sleep");
      while (sleep_active !== 1'b1 && n < 40) begin
         ticks(1);
         n++;
      end
      chk(n >= 12 && n < 40, "sleep after 512");
      apb(0, `SRT_OFF_STATUS, 0);
      chk(rd[1:0] === 2'h1, "soft phase");
      n = 0;
      while (rd[1:0] !== 2'h2 && n < 20) begin
         ticks(1);
         apb(0, `SRT_OFF_STATUS, 0);
         n++;
      end
      cond_en <= 1'b1;
      ticks(6);
      apb(0, `SRT_OFF_STATUS, 0);
      chk(rd[1:0] === 2'h2 && sleep_active === 1'b1, "hold ignores");
      n = 0;
      while (sleep_active !== 1'b0 && n < 30) begin
         ticks(1);
         n++;
      end
      chk(n >= 2 && n < 30, "sleep exit");
   endtask

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_strap(2'h2, 2'h3, 16'h0, 16'h7F00);
      t_nosleep;
      t_strap(2'h1, 2'h1, {1'b0, `SRT_DON_T2_1, 1'b0, `SRT_DOFF_T2}, 16'h7F7F);
      t_strap(2'h0, 2'h0, {1'b0, `SRT_DON_T1_0, 1'b0, `SRT_DOFF_T1}, 16'h7F7F);
      t_zcd;
      t_adp;
      t_below;
      t_sleep;
      results;
   end

   initial begin
      #4000000;
      errors++;
      results;
   end
endmodule
